// ---- src/qsh_defs.svh ----
/*
 * register offsets, field positions, reset values and counts for the quad serial port.
 * assumes inclusion by bare name from every design file that needs them.
 */
`ifndef QSH_DEFS_SVH
`define QSH_DEFS_SVH

// ****************************************************************
// apb byte offsets
// ****************************************************************
`define QSH_ADDR_W 8
`define QSH_OFF_CTRL 8'h00
`define QSH_OFF_MODE 8'h04
`define QSH_OFF_TXD 8'h08
`define QSH_OFF_RXD 8'h0C
`define QSH_OFF_INTF 8'h10
`define QSH_OFF_INTE 8'h14
`define QSH_OFF_TBEDMA 8'h18
`define QSH_OFF_RBFDMA 8'h1C
`define QSH_OFF_FRLDMA 8'h20

// ****************************************************************
// control register fields
// ****************************************************************
`define QSH_CTRL_MODULE_ENABLE_BIT 0
`define QSH_CTRL_SOFT_RESET_BIT 1
`define QSH_CTRL_SSO 2

// ****************************************************************
// mode register fields
// ****************************************************************
`define QSH_MODE_LEN_LO 8
`define QSH_MODE_LEN_HI 11
`define QSH_LEN_RESET 4'h7
`define QSH_LEN_MIN 4'h1

// ****************************************************************
// flag register fields
// ****************************************************************
`define QSH_F_TBE 0
`define QSH_F_RBF 1
`define QSH_F_TEND 2
`define QSH_F_OE 3
`define QSH_F_MAPPED_ACCESS_BUSY 6
`define QSH_F_BSY 7

// ****************************************************************
// reset values and counts
// ****************************************************************
`define QSH_WORD_RESET 16'h0000
`define QSH_SRST_CYCLES 2'h2
`define QSH_LINE_DOUT 0
`define QSH_LINE_DIN 1

`endif

// ---- src/qsh_pkg.sv ----
/*
 * types shared by the quad serial port modules.
 * assumes nothing beyond a sv-2012 compiler.
 */
package qsh_pkg;

  // ****************************************************************
  // shift engine states
  // ****************************************************************
  typedef enum logic [0:0] {
    QSH_IDLE = 1'b0,
    QSH_SHIFT = 1'b1
  } qsh_state_type;

  typedef logic [15:0] qsh_word_type;

endpackage

// ---- src/qsh_sync.sv ----
/*
 * two flip-flop synchroniser for levels entering the pclk domain.
 * assumes the input is a level that holds for several pclk periods.
 */
`timescale 1ns/10ps
`default_nettype none

module qsh_sync
  import qsh_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // ****************************************************************
  // first stage feeds only the second
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // qsh_sync

`default_nettype wire

// ---- src/qsh_shift.sv ----
/*
 * shift register and transfer bit counter, msb first, single line mode.
 * assumes link clock edges arrive as one-cycle pulses in the pclk domain.
 */
`timescale 1ns/10ps
`default_nettype none
`include "qsh_defs.svh"

module qsh_shift
  import qsh_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic run,
  input wire logic start,
  input wire logic [15:0] tx_word,
  input wire logic [3:0] len,
  input wire logic sclk_rise,
  input wire logic sclk_fall,
  input wire logic din,
  output logic busy,
  output logic done,
  output logic [15:0] rx_word,
  output logic dout
);

  qsh_state_type state_q;
  logic [15:0] shift_q;
  logic [3:0] cnt_q;
  logic [15:0] len_mask;
  logic [15:0] shifted;
  logic last_bit;
  logic step_rise;
  logic step_fall;

  // ****************************************************************
  // decode
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_mask
      assign len_mask[gi] = (4'(gi) <= len);
    end
  endgenerate

  assign shifted = {shift_q[14:0], din};
  assign last_bit = (cnt_q == len);
  // stopped clock: no edge counts while disabled
  assign step_rise = run && (state_q == QSH_SHIFT) && sclk_rise;
  assign step_fall = run && (state_q == QSH_SHIFT) && sclk_fall;
  assign busy = (state_q == QSH_SHIFT);

  // ****************************************************************
  // engine
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= QSH_IDLE;
      shift_q <= `QSH_WORD_RESET;
      cnt_q <= '0;
      done <= 1'b0;
      rx_word <= `QSH_WORD_RESET;
      dout <= 1'b0;
    end else if (clear) begin
      state_q <= QSH_IDLE;
      shift_q <= `QSH_WORD_RESET;
      cnt_q <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_q)
        QSH_IDLE: begin
          if (start) begin
            state_q <= QSH_SHIFT;
            shift_q <= tx_word;
            cnt_q <= '0;
            dout <= tx_word[len];
          end
        end
        QSH_SHIFT: begin
          if (step_rise) begin
            shift_q <= shifted;
            cnt_q <= cnt_q + 4'h1;
            if (last_bit) begin
              state_q <= QSH_IDLE;
              done <= 1'b1;
              rx_word <= shifted & len_mask;
            end
          end else if (step_fall) begin
            dout <= shift_q[len];
          end
        end
      endcase
    end
  end

endmodule // qsh_shift

`default_nettype wire

// ---- src/qsh_regs.sv ----
/*
 * apb register file, flags, dma requests and pin control of the quad serial port.
 * assumes an apb master on pclk, a link clock far slower than pclk, and
 * mapped-access signals driven by same-domain logic.
 */
//
// Contract
// - sso bit 0 drives select low
// - mapped access drives select; bit reads pin
// - soft reset clears shifter and counter
// - soft reset bit reads 1 until done
// - module enable runs or stops the port
// - transmit write loads buffer, starts transfer
// - transmit write accepted while shifting if empty
// - bits above length never shifted out
// - receive data readable while shifting continues
// - receive bits above length read zero
// - status bit 7 shows transfer busy
// - status bit 6 shows mapped access busy
// - flags 3..0 overrun, end, full, empty
// - write 1 clears overrun and end flags
// - receive-full clears on receive data read
// - transmit-empty resets 1, cleared by write
// - four enables gate each interrupt cause
// - transmit-empty dma enables per channel
// - receive-full dma enables per channel
// - prefetch-ready dma enables per channel
// - request only when flag and enable set
// - length field gives value plus one clocks
`timescale 1ns/10ps
`default_nettype none
`include "qsh_defs.svh"

module qsh_regs
  import qsh_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clk,
  input wire logic [3:0] serial_data_lines_in,
  output logic [3:0] serial_data_lines_out,
  output logic [3:0] serial_data_lines_oe_n,
  output logic chip_select_n_pin,
  input wire logic mapped_access_active,
  input wire logic mapped_access_select_n,
  input wire logic mapped_access_busy,
  input wire logic prefetch_ready,
  output logic [15:0] tx_empty_dma_req,
  output logic [15:0] rx_full_dma_req,
  output logic [15:0] prefetch_ready_dma_req,
  output logic port_irq
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic module_enable_bit_q;
  logic soft_reset_bit_q;
  logic [1:0] srst_cnt_q;
  logic select_output_control_q;
  logic [3:0] transfer_length_field_q;
  qsh_word_type transmit_data_buffer_q;
  qsh_word_type receive_data_buffer_q;
  logic transmit_empty_flag_q;
  logic receive_full_flag_q;
  logic end_of_transmission_flag_q;
  logic overrun_flag_q;
  logic [3:0] irq_enable_q;
  logic [15:0] tx_empty_dma_channel_enables_q;
  logic [15:0] rx_full_dma_channel_enables_q;
  logic [15:0] prefetch_ready_dma_channel_enables_q;
  logic [31:0] prdata_q;
  logic sclk_prev_q;

  // ****************************************************************
  // link side wires
  // ****************************************************************
  logic sclk_sync;
  logic din_sync;
  logic sclk_rise;
  logic sclk_fall;
  logic eng_busy;
  logic eng_done;
  logic eng_dout;
  qsh_word_type eng_rx_word;
  logic eng_start;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire [7:0] addr_lo = paddr[7:0];
  wire addr_hi_zero = (paddr[31:8] == 24'h000000);
  wire hit_ctrl = addr_hi_zero && (addr_lo == `QSH_OFF_CTRL);
  wire hit_mode = addr_hi_zero && (addr_lo == `QSH_OFF_MODE);
  wire hit_txd = addr_hi_zero && (addr_lo == `QSH_OFF_TXD);
  wire hit_rxd = addr_hi_zero && (addr_lo == `QSH_OFF_RXD);
  wire hit_intf = addr_hi_zero && (addr_lo == `QSH_OFF_INTF);
  wire hit_inte = addr_hi_zero && (addr_lo == `QSH_OFF_INTE);
  wire hit_tbedma = addr_hi_zero && (addr_lo == `QSH_OFF_TBEDMA);
  wire hit_rbfdma = addr_hi_zero && (addr_lo == `QSH_OFF_RBFDMA);
  wire hit_frldma = addr_hi_zero && (addr_lo == `QSH_OFF_FRLDMA);
  wire hit_any = hit_ctrl || hit_mode || hit_txd || hit_rxd || hit_intf || hit_inte
                 || hit_tbedma || hit_rbfdma || hit_frldma;
  wire access = psel && penable;
  wire setup = psel && !penable;
  // only the low half is mapped; byte lanes 2 and 3 are ignored
  wire lo_strb = pstrb[0] || pstrb[1];
  wire [15:0] wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire wr = access && pwrite && hit_any;
  wire wr_ctrl = wr && hit_ctrl && pstrb[0];
  wire wr_mode = wr && hit_mode && pstrb[1];
  wire wr_txd = wr && hit_txd && lo_strb;
  wire wr_intf = wr && hit_intf && pstrb[0];
  wire wr_inte = wr && hit_inte && pstrb[0];
  wire rd_rxd = access && !pwrite && hit_rxd;

  assign pready = 1'b1;
  assign pslverr = access && !hit_any;
  assign prdata = prdata_q;

  // ****************************************************************
  // status view
  // ****************************************************************
  wire [3:0] flags = {overrun_flag_q, end_of_transmission_flag_q,
                      receive_full_flag_q, transmit_empty_flag_q};
  wire [15:0] ctrl_view = {13'h0000, chip_select_n_pin, soft_reset_bit_q, module_enable_bit_q};
  wire [15:0] mode_view = {4'h0, transfer_length_field_q, 8'h00};
  wire [15:0] intf_view = {8'h00, eng_busy, mapped_access_busy, 2'b00, flags};
  wire [15:0] inte_view = {12'h000, irq_enable_q};
  wire [15:0] rd_view =
    hit_ctrl ? ctrl_view :
    hit_mode ? mode_view :
    hit_txd ? transmit_data_buffer_q :
    hit_rxd ? receive_data_buffer_q :
    hit_intf ? intf_view :
    hit_inte ? inte_view :
    hit_tbedma ? tx_empty_dma_channel_enables_q :
    hit_rbfdma ? rx_full_dma_channel_enables_q :
    hit_frldma ? prefetch_ready_dma_channel_enables_q : 16'h0000;

  // ****************************************************************
  // flag events
  // ****************************************************************
  // write with an empty flag of 0 is not blocked; its result is undefined
  wire txd_write = wr_txd;
  assign eng_start = !transmit_empty_flag_q && !eng_busy && module_enable_bit_q && !soft_reset_bit_q;
  wire tend_set = eng_done && transmit_empty_flag_q;
  wire oe_set = eng_done && receive_full_flag_q && !rd_rxd;
  wire oe_clr = wr_intf && pwdata[`QSH_F_OE];
  wire tend_clr = wr_intf && pwdata[`QSH_F_TEND];
  wire [3:0] len_wdata = pwdata[`QSH_MODE_LEN_HI:`QSH_MODE_LEN_LO];
  // zero is prohibited; hold the old length instead of taking it
  wire len_ok = (len_wdata >= `QSH_LEN_MIN);

  // ****************************************************************
  // outputs to pins, dma and interrupt
  // ****************************************************************
  assign chip_select_n_pin = mapped_access_active ? mapped_access_select_n : select_output_control_q;
  assign serial_data_lines_out = {3'b000, eng_dout};
  assign serial_data_lines_oe_n = {3'b111, !module_enable_bit_q};
  assign tx_empty_dma_req = tx_empty_dma_channel_enables_q & {16{transmit_empty_flag_q}};
  assign rx_full_dma_req = rx_full_dma_channel_enables_q & {16{receive_full_flag_q}};
  assign prefetch_ready_dma_req = prefetch_ready_dma_channel_enables_q & {16{prefetch_ready}};
  assign port_irq = |(flags & irq_enable_q);

  // ****************************************************************
  // link clock edges
  // ****************************************************************
  assign sclk_rise = sclk_sync && !sclk_prev_q;
  assign sclk_fall = !sclk_sync && sclk_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_sync;
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_enable_bit_q <= 1'b0;
      select_output_control_q <= 1'b1;
    end else if (wr_ctrl) begin
      module_enable_bit_q <= pwdata[`QSH_CTRL_MODULE_ENABLE_BIT];
      select_output_control_q <= pwdata[`QSH_CTRL_SSO];
    end
  end

  // soft reset holds the engine clear for a fixed count, then self-clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_reset_bit_q <= 1'b0;
      srst_cnt_q <= 2'h0;
    end else if (wr_ctrl && pwdata[`QSH_CTRL_SOFT_RESET_BIT]) begin
      soft_reset_bit_q <= 1'b1;
      srst_cnt_q <= `QSH_SRST_CYCLES;
    end else if (soft_reset_bit_q) begin
      srst_cnt_q <= srst_cnt_q - 2'h1;
      if (srst_cnt_q == 2'h1) begin
        soft_reset_bit_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // mode and enable registers
  // ****************************************************************
  // length may only change while the port is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transfer_length_field_q <= `QSH_LEN_RESET;
    end else if (wr_mode && !module_enable_bit_q && len_ok) begin
      transfer_length_field_q <= len_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_q <= 4'h0;
    end else if (wr_inte) begin
      irq_enable_q <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_dma_channel_enables_q <= `QSH_WORD_RESET;
      rx_full_dma_channel_enables_q <= `QSH_WORD_RESET;
      prefetch_ready_dma_channel_enables_q <= `QSH_WORD_RESET;
    end else if (wr) begin
      if (hit_tbedma) begin
        tx_empty_dma_channel_enables_q <= (tx_empty_dma_channel_enables_q & ~wmask) | (pwdata[15:0] & wmask);
      end
      if (hit_rbfdma) begin
        rx_full_dma_channel_enables_q <= (rx_full_dma_channel_enables_q & ~wmask) | (pwdata[15:0] & wmask);
      end
      if (hit_frldma) begin
        prefetch_ready_dma_channel_enables_q <= (prefetch_ready_dma_channel_enables_q & ~wmask)
                                                | (pwdata[15:0] & wmask);
      end
    end
  end

  // ****************************************************************
  // data buffers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_data_buffer_q <= `QSH_WORD_RESET;
    end else if (txd_write) begin
      transmit_data_buffer_q <= (transmit_data_buffer_q & ~wmask) | (pwdata[15:0] & wmask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_data_buffer_q <= `QSH_WORD_RESET;
    end else if (eng_done) begin
      receive_data_buffer_q <= eng_rx_word;
    end
  end

  // ****************************************************************
  // interrupt flags; a set in the same cycle as a clear wins
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_empty_flag_q <= 1'b1;
      receive_full_flag_q <= 1'b0;
      end_of_transmission_flag_q <= 1'b0;
      overrun_flag_q <= 1'b0;
    end else begin
      if (eng_start) begin
        transmit_empty_flag_q <= 1'b1;
      end else if (txd_write) begin
        transmit_empty_flag_q <= 1'b0;
      end
      if (eng_done) begin
        receive_full_flag_q <= 1'b1;
      end else if (rd_rxd) begin
        receive_full_flag_q <= 1'b0;
      end
      if (tend_set) begin
        end_of_transmission_flag_q <= 1'b1;
      end else if (tend_clr) begin
        end_of_transmission_flag_q <= 1'b0;
      end
      if (oe_set) begin
        overrun_flag_q <= 1'b1;
      end else if (oe_clr) begin
        overrun_flag_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // read data, captured in the setup phase
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup) begin
      prdata_q <= {16'h0000, rd_view};
    end
  end

  // ****************************************************************
  // submodules
  // ****************************************************************
  qsh_sync #(
    .WIDTH(2)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({serial_clk, serial_data_lines_in[`QSH_LINE_DIN]}),
    .sync_out({sclk_sync, din_sync})
  );

  qsh_shift u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .clear(soft_reset_bit_q),
    .run(module_enable_bit_q),
    .start(eng_start),
    .tx_word(transmit_data_buffer_q),
    .len(transfer_length_field_q),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall),
    .din(din_sync),
    .busy(eng_busy),
    .done(eng_done),
    .rx_word(eng_rx_word),
    .dout(eng_dout)
  );

endmodule // qsh_regs

`default_nettype wire

// ---- tb/qsh_regs_asserts.sv ----
/* checker for qsh_regs: select, flags, dma gating and interrupt masking seen at the ports.
   assumes bind onto qsh_regs and a single pclk domain. */
`timescale 1ns/10ps
`default_nettype none
`include "qsh_defs.svh"

module qsh_regs_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic chip_select_n_pin,
  input wire logic [3:0] serial_data_lines_oe_n,
  input wire logic mapped_access_active,
  input wire logic mapped_access_select_n,
  input wire logic mapped_access_busy,
  input wire logic prefetch_ready,
  input wire logic [15:0] tx_empty_dma_req,
  input wire logic [15:0] rx_full_dma_req,
  input wire logic [15:0] prefetch_ready_dma_req,
  input wire logic port_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_setup = psel && !penable && !pwrite;
  wire wr_acc = psel && penable && pwrite;
  wire rd_acc = psel && penable && !pwrite;
  wire ctrl_wr = wr_acc && pstrb[0] && paddr == {24'h000000, `QSH_OFF_CTRL};

  a_select_mapped: assert property (mapped_access_active |-> chip_select_n_pin == mapped_access_select_n)
    else $error("select pin not taken from mapped access");
  a_select_readback: assert property (rd_setup && paddr == {24'h000000, `QSH_OFF_CTRL} |=>
    prdata[2] == $past(chip_select_n_pin)) else $error("select bit does not show pin");
  a_mapped_busy: assert property (rd_setup && paddr == {24'h000000, `QSH_OFF_INTF} |=>
    prdata[6] == $past(mapped_access_busy)) else $error("mapped busy bit wrong");
  a_select_write: assert property (ctrl_wr |=>
    mapped_access_active || chip_select_n_pin == $past(pwdata[2])) else $error("select pin not per bit");
  a_enable_pin: assert property (ctrl_wr |=> serial_data_lines_oe_n[0] == !$past(pwdata[0]))
    else $error("data line enable not per module enable");
  a_txd_empty: assert property (wr_acc && paddr == {24'h000000, `QSH_OFF_TXD} |=> tx_empty_dma_req == 16'h0000)
    else $error("transmit empty not cleared by write");
  a_rxd_full: assert property (rd_acc && paddr == {24'h000000, `QSH_OFF_RXD} |=> rx_full_dma_req == 16'h0000)
    else $error("receive full not cleared by read");
  a_prefetch_gate: assert property (prefetch_ready_dma_req != 16'h0000 |-> prefetch_ready)
    else $error("prefetch request without ready");
  a_irq_masked: assert property (wr_acc && paddr == {24'h000000, `QSH_OFF_INTE} && pwdata[3:0] == 4'h0 |=>
    !port_irq) else $error("interrupt with all enables off");
endmodule // qsh_regs_asserts

bind qsh_regs qsh_regs_asserts chk (.*);
`default_nettype wire

// ---- tb/qsh_flash_model.sv ----
/* serial peripheral model: runs the link clock only within a frame, sends msb first.
   assumes the bench pulses go with the slow flag and reply word set. */
`timescale 1ns/10ps
`default_nettype none

module qsh_flash_model (
  input wire logic go,
  input wire logic slow,
  input wire logic [15:0] reply,
  input wire logic cs_n,
  input wire logic mosi,
  output logic sclk,
  output logic miso,
  output logic [15:0] cap,
  output logic busy
);
  initial begin
    sclk = 1'b0;
    miso = 1'b0;
    cap = 16'h0000;
    busy = 1'b0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      // clock stands still for a while before a late frame
      if (slow)
        #640;
      for (int i = 11; i >= 0; i--) begin
        miso = reply[i];
        #160 sclk = 1'b1;
        if (!cs_n)
          cap = {cap[14:0], mosi};
        #160 sclk = 1'b0;
      end
      // released line: never leave the last bit standing
      miso = ~miso;
      busy = 1'b0;
    end
  end
endmodule // qsh_flash_model
`default_nettype wire

// ---- tb/qsh_regs_bench.sv ----
/* bench for qsh_regs: register table loop, then frames, overrun, masking, soft reset, mapped
   access and a second reset. assumes the model supplies 12-clock frames. */
`timescale 1ns/10ps
`default_nettype none
`include "qsh_defs.svh"

module qsh_regs_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [3:0] lo, oe_n;
  logic pready, pslverr, sclk, miso, cs_n, irq, err, mbusy, go = 1'b0, slow = 1'b0;
  logic ma_act = 1'b0, ma_sel_n = 1'b1, ma_busy = 1'b0, pf_rdy = 1'b0;
  logic [15:0] txq, rxq, pfq, cap, reply = 16'h0;
  int mismatches = 0, checks = 0, cyc = 0;
  logic [31:0] rows [14][3] = '{'{32'h0, 32'h0, 32'h4}, '{32'h4, 32'h0, 32'h700},
    '{32'h8, 32'h0, 32'h0}, '{32'hC, 32'h0, 32'h0}, '{32'h10, 32'h0, 32'h1}, '{32'h14, 32'h0, 32'h0},
    '{32'h18, 32'h0, 32'h0}, '{32'h1C, 32'h0, 32'h0}, '{32'h20, 32'h0, 32'h0},
    '{32'h14, 32'hFFFFFFFF, 32'hF}, '{32'h18, 32'h1234A5A5, 32'hA5A5}, '{32'h1C, 32'h5A5A, 32'h5A5A},
    '{32'h20, 32'hFFFF, 32'hFFFF}, '{32'h10, 32'h10000000, 32'h1}};

  always #20 pclk = ~pclk;

  qsh_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clk(sclk), .serial_data_lines_in({2'b11, miso, lo[0]}), .serial_data_lines_out(lo),
    .serial_data_lines_oe_n(oe_n), .chip_select_n_pin(cs_n), .mapped_access_active(ma_act),
    .mapped_access_select_n(ma_sel_n), .mapped_access_busy(ma_busy), .prefetch_ready(pf_rdy),
    .tx_empty_dma_req(txq), .rx_full_dma_req(rxq), .prefetch_ready_dma_req(pfq), .port_irq(irq));

  qsh_flash_model dev (.go(go), .slow(slow), .reply(reply), .cs_n(cs_n), .mosi(lo[0]), .sclk(sclk),
    .miso(miso), .cap(cap), .busy(mbusy));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // the only bound on every wait in this bench
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the write's edge settle before any caller looks at pins
    @(posedge pclk);
  endtask

  task automatic xfer(input logic [15:0] tx, input logic [15:0] rep, input logic s);
    apb(1'b1, `QSH_OFF_TXD, {16'h0000, tx});
    reply <= rep;
    slow <= s;
    go <= 1'b1;
    apb(1'b0, `QSH_OFF_INTF, 32'h0);
    chk("busy and empty", rd & 32'h81, 32'h81);
    go <= 1'b0;
    while (mbusy === 1'b1)
      @(posedge pclk);
    repeat (12) @(posedge pclk);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i][1] != 32'h0)
        apb(1'b1, rows[i][0][7:0], rows[i][1]);
      apb(1'b0, rows[i][0][7:0], 32'h0);
      chk("register", rd, rows[i][2]);
    end
    chk("irq", 32'(irq), 32'h1);
    chk("tx dma", 32'(txq), 32'hA5A5);
    chk("pf dma", 32'(pfq), 32'h0);
    pf_rdy <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("pf dma", 32'(pfq), 32'hFFFF);
    apb(1'b1, `QSH_OFF_MODE, 32'hB00);
    apb(1'b1, `QSH_OFF_MODE, 32'h0);
    apb(1'b0, `QSH_OFF_MODE, 32'h0);
    chk("length", rd & 32'hF00, 32'hB00);
    apb(1'b1, `QSH_OFF_CTRL, 32'h1);
    chk("select", 32'(cs_n), 32'h0);
    chk("line enable", 32'(oe_n[0]), 32'h0);
    xfer(16'hF5A3, 16'hFABC, 1'b0);
    chk("sent bits", 32'(cap[11:0]), 32'h5A3);
    apb(1'b0, `QSH_OFF_INTF, 32'h0);
    chk("flags", rd, 32'h7);
    chk("rx dma", 32'(rxq), 32'h5A5A);
    apb(1'b0, `QSH_OFF_RXD, 32'h0);
    chk("rx data", rd, 32'hABC);
    apb(1'b0, `QSH_OFF_INTF, 32'h0);
    chk("flags", rd, 32'h5);
    apb(1'b1, `QSH_OFF_INTF, 32'h4);
    apb(1'b0, `QSH_OFF_INTF, 32'h0);
    chk("flags", rd, 32'h1);
    xfer(16'h0123, 16'h0F0F, 1'b0);
    xfer(16'h0456, 16'h0777, 1'b1);
    apb(1'b0, `QSH_OFF_INTF, 32'h0);
    chk("overrun", rd, 32'hF);
    apb(1'b1, `QSH_OFF_INTF, 32'h8);
    apb(1'b0, `QSH_OFF_INTF, 32'h0);
    chk("flags", rd, 32'h7);
    apb(1'b0, `QSH_OFF_RXD, 32'h0);
    chk("rx data", rd, 32'h777);
    apb(1'b1, `QSH_OFF_INTE, 32'h0);
    chk("irq", 32'(irq), 32'h0);
    // no link clock here, so the engine stays busy until aborted
    apb(1'b1, `QSH_OFF_TXD, 32'h1234);
    apb(1'b0, `QSH_OFF_INTF, 32'h0);
    chk("busy", rd & 32'h80, 32'h80);
    apb(1'b1, `QSH_OFF_CTRL, 32'h3);
    apb(1'b0, `QSH_OFF_INTF, 32'h0);
    chk("busy", rd & 32'h80, 32'h0);
    apb(1'b0, `QSH_OFF_CTRL, 32'h0);
    chk("ctrl", rd, 32'h1);
    ma_act <= 1'b1;
    ma_busy <= 1'b1;
    apb(1'b0, `QSH_OFF_CTRL, 32'h0);
    chk("ctrl", rd, 32'h5);
    apb(1'b0, `QSH_OFF_INTF, 32'h0);
    chk("mapped busy", rd & 32'h40, 32'h40);
    ma_act <= 1'b0;
    ma_busy <= 1'b0;
    apb(1'b1, `QSH_OFF_CTRL, 32'h4);
    chk("line enable", 32'(oe_n), 32'hF);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `QSH_OFF_INTF, 32'h0);
    chk("flags", rd, 32'h1);
    tally_and_finish();
  end
endmodule // qsh_regs_bench
`default_nettype wire
